// ### bench/ahrp_dev_model.sv
/* Behavioural register port device: latch, 256 bytes, two irq sources.
 Assumes the bench resolves the data bus and the pulled-up interrupt line. */
`timescale 1ns/1ps
module ahrp_dev_model #(
    parameter logic [7:0] mask_addr = 8'h01,
    parameter logic [7:0] ack_addr = 8'h02
) (
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic addr_latch_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] bus,
    input wire logic async_reset_n,
    input wire logic [1:0] irq_event,
    output logic drive_en,
    output logic [7:0] drive_val,
    output logic int_low
);
    logic [7:0] mem [256];
    logic [7:0] lat;
    logic [1:0] pend;
    always @*
        if (addr_latch_en) lat = addr;
    assign drive_en = !chip_select_n && !read_strobe_n;
    assign drive_val = mem[lat];
    always @(posedge write_strobe_n)
        if (!chip_select_n && async_reset_n) mem[lat] = bus;
    always @(negedge async_reset_n)
    begin
        foreach (mem[i]) mem[i] = 8'h00;
        pend = 2'h0;
    end
    always @(posedge irq_event[0]) pend[0] = 1'b1;
    always @(posedge irq_event[1]) pend[1] = 1'b1;
    always @(posedge read_strobe_n)
        if (!chip_select_n && lat == ack_addr) pend = 2'h0;
    // only ever a pull-down request, the bench supplies the pull-up
    assign int_low = |(pend & mem[mask_addr][1:0]);
endmodule

// ### bench/ahrp_host_props.sv
/* Pin sequencing checker for the host port controller.
 Assumes binding to ahrp_host and its default strobe counts. */
`timescale 1ns/1ps
module ahrp_host_props #(
    parameter int setup_cyc = 2,
    parameter int strobe_cyc = 5,
    parameter int hold_cyc = 2
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic done,
    input wire logic irq_pending,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic addr_latch_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic dev_reset_req,
    input wire logic async_reset_n,
    input wire logic interrupt_out_n
);
    // strobe is stretched by the two-flop read sampler
    localparam int str_len = strobe_cyc + 2;
    localparam int to_done = setup_cyc + str_len + hold_cyc + 1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_rd_in_cs: assert property (
        !read_strobe_n |-> !chip_select_n && !data_oe)
        else $error("read strobe outside select");
    a_wr_in_cs: assert property (
        !write_strobe_n |-> !chip_select_n && data_oe && $stable(data_out))
        else $error("write data unstable");
    a_rd_len: assert property (
        $fell(read_strobe_n) |-> ##str_len $rose(read_strobe_n))
        else $error("read strobe length");
    a_wr_len: assert property (
        $fell(write_strobe_n) |-> ##str_len $rose(write_strobe_n))
        else $error("write strobe length");
    a_addr_hold: assert property (
        !chip_select_n && !$past(chip_select_n) |-> $stable(addr))
        else $error("address moved in access");
    a_ale_setup: assert property (
        $rose(addr_latch_en) |->
        $fell(chip_select_n) ##setup_cyc !addr_latch_en)
        else $error("latch enable timing");
    a_done_time: assert property (
        $fell(chip_select_n) |-> ##to_done done)
        else $error("done late");
    a_irq_seen: assert property (
        $fell(interrupt_out_n) |-> ##[2:4] irq_pending)
        else $error("interrupt missed");
    a_irq_gone: assert property (
        $rose(interrupt_out_n) |-> ##[2:4] !irq_pending)
        else $error("interrupt stuck");
    a_dev_reset: assert property (
        dev_reset_req |=> !async_reset_n)
        else $error("device reset not driven");
endmodule
bind ahrp_host ahrp_host_props #(
    .setup_cyc(setup_cyc),
    .strobe_cyc(strobe_cyc),
    .hold_cyc(hold_cyc)
) u_props (
    .mclk(mclk),
    .rst_b(rst_b),
    .done(done),
    .irq_pending(irq_pending),
    .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .addr_latch_en(addr_latch_en),
    .addr(addr),
    .data_out(data_out),
    .data_oe(data_oe),
    .dev_reset_req(dev_reset_req),
    .async_reset_n(async_reset_n),
    .interrupt_out_n(interrupt_out_n)
);

// ### bench/ahrp_host_tb.sv
/* Self-checking bench for ahrp_host against the device model.
 Assumes default strobe counts; clk_en is frozen once in mid-run. */
`timescale 1ns/1ps
module ahrp_host_tb;
    logic mclk = 0, rst_b = 0, req = 0, req_write = 0, req_test = 0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_wdata = 8'h00, rdata, addr, data_out, bus, last = 8'h00;
    logic dev_reset_req = 0, busy, done, irq_pending, chip_select_n;
    logic read_strobe_n, write_strobe_n, addr_latch_en, data_oe;
    logic async_reset_n, interrupt_out_n, drive_en, int_low;
    logic [7:0] drive_val, a, d, q;
    logic [1:0] irq_event = 2'h0;
    logic clk_en = 1;
    logic [7:0] shadow [256];
    int fails = 0, num_checks = 0, seed = 42;
    always #10 mclk = ~mclk;
    // undriven bus shows the inverse of its last level
    always @* bus = data_oe ? data_out : drive_en ? drive_val : ~last;
    always @(posedge mclk)
        if (data_oe || drive_en) last <= bus;
    assign interrupt_out_n = int_low ? 1'b0 : 1'b1;
    ahrp_host uut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
        .req_write(req_write), .req_test(req_test), .req_addr(req_addr),
        .req_wdata(req_wdata), .dev_reset_req(dev_reset_req), .busy(busy),
        .done(done), .rdata(rdata), .irq_pending(irq_pending),
        .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .addr_latch_en(addr_latch_en),
        .addr(addr), .data_out(data_out), .data_oe(data_oe), .data_in(bus),
        .async_reset_n(async_reset_n), .interrupt_out_n(interrupt_out_n));
    ahrp_dev_model dev (.chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .addr_latch_en(addr_latch_en), .addr(addr), .bus(bus),
        .async_reset_n(async_reset_n), .irq_event(irq_event),
        .drive_en(drive_en), .drive_val(drive_val), .int_low(int_low));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // expected read value from the bench's own register shadow
    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        exp_rd = shadow[ad];
    endfunction
    // expected irq level: any enabled source with a pending event
    function automatic logic [7:0] exp_irq(input logic [1:0] mask,
        input logic [1:0] pend);
        exp_irq = {7'h00, |(mask & pend)};
    endfunction
    task automatic acc(input logic w, input logic [7:0] ad,
        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge mclk);
        req <= 1'b1;
        req_write <= w;
        req_test <= ad[7];
        req_addr <= ad[6:0];
        req_wdata <= wd;
        for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge mclk);
        if (n == 40) fails++;
        rd = rdata;
        if (w) shadow[ad] = wd;
        @(posedge mclk);
        req <= 1'b0;
    endtask
    task final_report;
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({7'h00, async_reset_n}, 8'h01);
        for (int i = 0; i < 10; i++)
        begin
            a = (i == 0) ? 8'hFF : $random(seed);
            if (a[6:0] < 7'h03) a[6:0] = 7'h03;
            d = $random(seed);
            acc(1'b1, a, d, q);
            acc(1'b1, a ^ 8'h80, ~d, q);
            acc(1'b0, a, 8'h00, q);
            chk(q, exp_rd(a));
        end
        // frozen clock enable: a pending request must not start
        clk_en <= 1'b0;
        fork
            acc(1'b0, a, 8'h00, q);
            begin
                repeat (6) @(posedge mclk);
                chk({7'h00, busy}, 8'h00);
                chk({7'h00, chip_select_n}, 8'h01);
                clk_en <= 1'b1;
                repeat (3) @(posedge mclk);
                chk({7'h00, busy}, 8'h01);
                chk({7'h00, chip_select_n}, 8'h00);
            end
        join
        chk(q, exp_rd(a));
        acc(1'b1, 8'h01, 8'h01, q);
        irq_event <= 2'h2;
        repeat (8) @(posedge mclk);
        chk({7'h00, irq_pending}, exp_irq(2'h1, 2'h2));
        irq_event <= 2'h3;
        repeat (8) @(posedge mclk);
        chk({7'h00, irq_pending}, exp_irq(2'h1, 2'h3));
        chk({7'h00, interrupt_out_n}, 8'h00);
        irq_event <= 2'h0;
        acc(1'b0, 8'h02, 8'h00, q);
        repeat (8) @(posedge mclk);
        chk({7'h00, irq_pending}, 8'h00);
        dev_reset_req <= 1'b1;
        repeat (4) @(posedge mclk);
        dev_reset_req <= 1'b0;
        repeat (3) @(posedge mclk);
        acc(1'b0, a, 8'h00, q);
        chk(q, 8'h00);
        final_report;
    end
    initial
    begin
        #200000;
        fails++;
        final_report;
    end
endmodule

// ### verilog/ahrp_host.sv
/*
 Host controller driving an asynchronous 8-bit register port: chip select,
 read and write strobes, address with latch enable, two-way data bus,
 device reset, and the open-drain interrupt line sampled back.
 Assumes the user side issues one request at a time, holding it until
 done pulses; the device returns read data while select and read are low.
*/
`timescale 1ns/1ps
module ahrp_host #(
    parameter int setup_cyc = ahrp_pkg::ahrp_setup_cyc,
    parameter int strobe_cyc = ahrp_pkg::ahrp_strobe_cyc,
    parameter int hold_cyc = ahrp_pkg::ahrp_hold_cyc
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic req,
    input wire logic req_write,
    input wire logic req_test,
    input wire logic [6:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic dev_reset_req,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    output logic irq_pending,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic addr_latch_en,
    output logic [7:0] addr,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [7:0] data_in,
    output logic async_reset_n,
    input wire logic interrupt_out_n
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ahrp_pkg::ahrp_state_type state;
        logic [ahrp_pkg::ahrp_cnt_w-1:0] cnt;
        logic write;
        logic busy;
        logic done;
        logic [7:0] rdata;
        logic irq_pending;
        logic chip_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic addr_latch_en;
        logic [7:0] addr;
        logic [7:0] data_out;
        logic data_oe;
        logic async_reset_n;
    } ahrp_host_type;

    ahrp_host_type st;
    ahrp_host_type next_st;
    logic [7:0] data_sync;
    logic irq_sync_n;

    function automatic logic [ahrp_pkg::ahrp_cnt_w-1:0] cyc(input int n);
        cyc = (n < 1) ? 8'h01 : n[ahrp_pkg::ahrp_cnt_w-1:0];
    endfunction

    // ------------------------------------------------------------
    // pin inputs cross two flops; read data settles during strobe
    // ------------------------------------------------------------
    ahrp_sync #(.width(9)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .async_in({interrupt_out_n, data_in}),
        .reset_val(9'h1FF),
        .sync_out({irq_sync_n, data_sync})
    );

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        // open-drain line: low means an unmasked source is active
        next_st.irq_pending = ~irq_sync_n;
        next_st.async_reset_n = ~dev_reset_req;
        if (st.cnt != ahrp_pkg::ahrp_cnt_zero)
        begin
            next_st.cnt = st.cnt - 8'h01;
        end
        unique case (st.state)
            ahrp_pkg::ahrp_idle:
            begin
                next_st.chip_select_n = 1'b1;
                next_st.read_strobe_n = 1'b1;
                next_st.write_strobe_n = 1'b1;
                next_st.data_oe = 1'b0;
                next_st.addr_latch_en = 1'b0;
                // no access while the device is held in reset
                if (req && !dev_reset_req && !st.done)
                begin
                    next_st.state = ahrp_pkg::ahrp_addr;
                    next_st.busy = 1'b1;
                    next_st.write = req_write;
                    next_st.addr = {req_test, req_addr};
                    next_st.addr_latch_en = 1'b1;
                    next_st.chip_select_n = 1'b0;
                    next_st.data_out = req_wdata;
                    next_st.data_oe = req_write;
                    next_st.cnt = cyc(setup_cyc);
                end
            end
            ahrp_pkg::ahrp_addr:
            begin
                if (st.cnt == 8'h01)
                begin
                    // latch closes on the same edge the strobe falls, address stays held
                    next_st.addr_latch_en = 1'b0;
                    next_st.state = ahrp_pkg::ahrp_strobe;
                    next_st.read_strobe_n = st.write;
                    next_st.write_strobe_n = ~st.write;
                    next_st.cnt = cyc(strobe_cyc + 2);
                end
            end
            ahrp_pkg::ahrp_strobe:
            begin
                if (st.cnt == 8'h01)
                begin
                    // two extra cycles cover the synchroniser delay
                    if (!st.write)
                    begin
                        next_st.rdata = data_sync;
                    end
                    // rising write edge stores data, select still low
                    next_st.read_strobe_n = 1'b1;
                    next_st.write_strobe_n = 1'b1;
                    next_st.state = ahrp_pkg::ahrp_hold;
                    next_st.cnt = cyc(hold_cyc);
                end
            end
            ahrp_pkg::ahrp_hold:
            begin
                if (st.cnt == 8'h01)
                begin
                    next_st.chip_select_n = 1'b1;
                    next_st.data_oe = 1'b0;
                    next_st.state = ahrp_pkg::ahrp_done;
                end
            end
            ahrp_pkg::ahrp_done:
            begin
                // acknowledge by register access is the user's read/write
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.state = ahrp_pkg::ahrp_idle;
            end
            default:
            begin
                next_st.state = ahrp_pkg::ahrp_idle;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.state <= ahrp_pkg::ahrp_idle;
            st.chip_select_n <= 1'b1;
            st.read_strobe_n <= 1'b1;
            st.write_strobe_n <= 1'b1;
            st.async_reset_n <= 1'b0;
        end
        else if (clk_en)
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state flops
    // ------------------------------------------------------------
    assign busy = st.busy;
    assign done = st.done;
    assign rdata = st.rdata;
    assign irq_pending = st.irq_pending;
    assign chip_select_n = st.chip_select_n;
    assign read_strobe_n = st.read_strobe_n;
    assign write_strobe_n = st.write_strobe_n;
    assign addr_latch_en = st.addr_latch_en;
    assign addr = st.addr;
    assign data_out = st.data_out;
    assign data_oe = st.data_oe;
    assign async_reset_n = st.async_reset_n;
endmodule

// ### verilog/ahrp_pkg.sv
/*
 Constants for the host-side controller of an asynchronous 8-bit register port.
 Assumes a 50 MHz mclk; all strobe timing is expressed in mclk cycles.
*/
package ahrp_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ahrp_addr_w = 8;
    localparam int ahrp_data_w = 8;
    localparam int ahrp_test_bit = 7;

    // ------------------------------------------------------------
    // timing, in ns with derived cycle counts
    // ------------------------------------------------------------
    localparam int ahrp_clk_ns = 20;
    localparam int ahrp_setup_ns = 40;
    localparam int ahrp_strobe_ns = 100;
    localparam int ahrp_hold_ns = 40;
    localparam int ahrp_setup_cyc = (ahrp_setup_ns + ahrp_clk_ns - 1)
        / ahrp_clk_ns;
    localparam int ahrp_strobe_cyc = (ahrp_strobe_ns + ahrp_clk_ns - 1)
        / ahrp_clk_ns;
    localparam int ahrp_hold_cyc = (ahrp_hold_ns + ahrp_clk_ns - 1)
        / ahrp_clk_ns;
    localparam int ahrp_cnt_w = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ahrp_zero8 = 8'h00;
    localparam logic [ahrp_cnt_w-1:0] ahrp_cnt_zero = 8'h00;

    // ------------------------------------------------------------
    // sequencer states, gray along idle-addr-strobe-hold-done
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ahrp_idle = 3'h0,
        ahrp_addr = 3'h1,
        ahrp_strobe = 3'h3,
        ahrp_hold = 3'h2,
        ahrp_done = 3'h6
    } ahrp_state_type;
endpackage

// ### verilog/ahrp_sync.sv
/*
 Two-flop synchroniser for pin inputs.
 Assumes inputs are asynchronous to mclk; first flop read only by the second.
*/
`timescale 1ns/1ps
module ahrp_sync #(
    parameter int width = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [width-1:0] async_in,
    input wire logic [width-1:0] reset_val,
    output logic [width-1:0] sync_out
);
    typedef struct packed {
        logic [width-1:0] meta;
        logic [width-1:0] out;
    } ahrp_sync_type;

    ahrp_sync_type st;
    ahrp_sync_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.meta = async_in;
        next_st.out = st.meta;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st.meta <= reset_val;
            st.out <= reset_val;
        end
        else if (clk_en)
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.out;
endmodule
